// ===== pm_defs.svh
// Offsets, reset values, field positions and codes of the port function mux.
// Assumes the extended register space carries 12-bit addresses and 8-bit data.
`ifndef PM_DEFS_SVH
`define PM_DEFS_SVH

// ==========================================================================
// Register offsets
`define PM_ADDR_W          12
`define PM_OFS_PF_KIND     12'h024
`define PM_OFS_PA_SEL_HI   12'h025
`define PM_OFS_PA_SEL_LO   12'h026
`define PM_OFS_PB_SEL_HI   12'h027
`define PM_OFS_PB_SEL_LO   12'h028
`define PM_OFS_PC_SEL_HI   12'h029
`define PM_OFS_PC_SEL_LO   12'h02A
`define PM_OFS_PG_DIR      12'h210
`define PM_OFS_PG_DATA     12'h211
`define PM_OFS_PG_PULL     12'h212

// ==========================================================================
// Reset values and implemented-bit masks
`define PM_RST_SEL         8'h00
`define PM_RST_PF_KIND     8'hF7
`define PM_RST_PG_DIR      6'h00
`define PM_RST_PG_DATA     6'h00
`define PM_RST_PG_PULL     6'h3F
`define PM_MASK_PA_HI      8'hF8
`define PM_MASK_PA_LO      8'hE2
`define PM_MASK_PF_KIND    8'hF7

// ==========================================================================
// Field positions and selection codes
`define PM_PA7_LSB         6
`define PM_PA6_LSB         4
`define PM_PA5_BIT         3
`define PM_PA3_LSB         6
`define PM_PA2_BIT         5
`define PM_PA0_BIT         1
`define PM_PF_IN_ONLY_BIT  3
`define PM_SEL_GPIO        2'h0
`define PM_SEL_ALT1        2'h1
`define PM_SEL_ALT2        2'h2
`define PM_SEL_ALT3        2'h3

`endif

// ===== pm_pkg.sv
// Types shared by the port function mux and its users.
// Assumes pm_defs.svh is on the include path.
`include "pm_defs.svh"

package pm_pkg;

    // ======================================================================
    // Pin routing
    typedef enum logic [2:0] {
        PM_RT_GPIO,
        PM_RT_ALT1,
        PM_RT_ALT2,
        PM_RT_ALT3,
        PM_RT_CLAIM,
        PM_RT_NONE
    } pm_route_e;

    typedef struct packed {
        pm_route_e [7:0] pin;
    } pm_port_route_s;

    typedef struct packed {
        logic sub_xtal;
        logic main_xtal;
        logic i2c_scl_pe7;
        logic uart0_tx_b_pc0;
        logic uart0_rx_a_pb0;
    } pm_claim_s;

    // ======================================================================
    // Extended register space access
    typedef struct packed {
        logic                     wr;
        logic                     rd;
        logic [`PM_ADDR_W-1:0]    addr;
        logic [7:0]               wdata;
    } pm_xfr_req_s;

endpackage : pm_pkg

// ===== pm_port_mux.sv
// Port A/B/C function selection, port G GPIO and port F output kind.
// Assumes a core that writes and reads the extended register space.
`timescale 1ns/1ps
`include "pm_defs.svh"

module pm_port_mux #(
    parameter int PG_W = 6
) (
    // Clock and reset
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_rst_n,
    // Extended register space
    input  wire pm_pkg::pm_xfr_req_s    i_xfr,
    output logic [7:0]                  o_xfr_rdata,
    // Port G pins
    input  wire logic [PG_W-1:0]        i_pg_pin,
    output logic [PG_W-1:0]             o_pg_out,
    output logic [PG_W-1:0]             o_pg_oe,
    output logic [PG_W-1:0]             o_pg_pullup_en,
    // Port F output kind
    output logic [7:0]                  o_pf_output_kind_bits,
    // Pin routing
    output pm_pkg::pm_port_route_s      o_pa_route,
    output pm_pkg::pm_port_route_s      o_pb_route,
    output pm_pkg::pm_port_route_s      o_pc_route,
    output pm_pkg::pm_claim_s           o_claim
);
    import pm_pkg::*;

    // ======================================================================
    // Register state
    logic [7:0]      pa_hi_r, pa_lo_r, pb_hi_r, pb_lo_r, pc_hi_r, pc_lo_r;
    logic [7:0]      pf_kind_r;
    logic [PG_W-1:0] port_g_direction_bits;
    logic [PG_W-1:0] port_g_pin_data_bits;
    logic [PG_W-1:0] port_g_pullup_off_bits;
    logic [PG_W-1:0] pg_s1_r, pg_s2_r, pg_s3_r, pg_in_r;
    logic [7:0]      rdata_nxt;

    function automatic logic wr_at(input logic [`PM_ADDR_W-1:0] a);
        return i_xfr.wr && (i_xfr.addr == a);
    endfunction : wr_at

    function automatic pm_route_e route_of(input logic [1:0] code,
                                           input logic [3:0] resv);
        pm_route_e r;
        r = PM_RT_NONE;
        if (!resv[code]) begin
            case (code)
                `PM_SEL_ALT1: r = PM_RT_ALT1;
                `PM_SEL_ALT2: r = PM_RT_ALT2;
                `PM_SEL_ALT3: r = PM_RT_ALT3;
                default:      r = PM_RT_GPIO;
            endcase
        end
        return r;
    endfunction : route_of

    // ======================================================================
    // Selection registers; claimed partner fields keep their stored value
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pa_hi_r <= `PM_RST_SEL;
            pa_lo_r <= `PM_RST_SEL;
            pb_hi_r <= `PM_RST_SEL;
            pb_lo_r <= `PM_RST_SEL;
            pc_hi_r <= `PM_RST_SEL;
            pc_lo_r <= `PM_RST_SEL;
        end else begin
            if (wr_at(`PM_OFS_PA_SEL_HI)) pa_hi_r <= i_xfr.wdata & `PM_MASK_PA_HI;
            if (wr_at(`PM_OFS_PA_SEL_LO)) pa_lo_r <= i_xfr.wdata & `PM_MASK_PA_LO;
            if (wr_at(`PM_OFS_PB_SEL_HI)) pb_hi_r <= i_xfr.wdata;
            if (wr_at(`PM_OFS_PB_SEL_LO)) pb_lo_r <= i_xfr.wdata;
            if (wr_at(`PM_OFS_PC_SEL_HI)) pc_hi_r <= i_xfr.wdata;
            if (wr_at(`PM_OFS_PC_SEL_LO)) pc_lo_r <= i_xfr.wdata;
        end
    end

    // ======================================================================
    // Port F output kind; pin 3 held at open-drain
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pf_kind_r <= `PM_RST_PF_KIND;
        end else if (wr_at(`PM_OFS_PF_KIND)) begin
            pf_kind_r <= i_xfr.wdata & `PM_MASK_PF_KIND;
        end
    end
    assign o_pf_output_kind_bits = pf_kind_r;

    // ======================================================================
    // Port G registers
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            port_g_direction_bits  <= `PM_RST_PG_DIR;
            port_g_pin_data_bits   <= `PM_RST_PG_DATA;
            port_g_pullup_off_bits <= `PM_RST_PG_PULL;
        end else begin
            if (wr_at(`PM_OFS_PG_DIR))
                port_g_direction_bits <= i_xfr.wdata[PG_W-1:0];
            if (wr_at(`PM_OFS_PG_DATA))
                port_g_pin_data_bits <= i_xfr.wdata[PG_W-1:0];
            if (wr_at(`PM_OFS_PG_PULL))
                port_g_pullup_off_bits <= i_xfr.wdata[PG_W-1:0];
        end
    end
    assign o_pg_oe        = port_g_direction_bits;
    assign o_pg_out       = port_g_pin_data_bits;
    assign o_pg_pullup_en = ~port_g_pullup_off_bits;

    // Pin sampling; value moves only when stages two and three agree
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pg_s1_r <= '0;
            pg_s2_r <= '0;
            pg_s3_r <= '0;
            pg_in_r <= '0;
        end else begin
            pg_s1_r <= i_pg_pin;
            pg_s2_r <= pg_s1_r;
            pg_s3_r <= pg_s2_r;
            for (int i = 0; i < PG_W; i++) begin
                if (pg_s2_r[i] == pg_s3_r[i])
                    pg_in_r[i] <= pg_s3_r[i];
            end
        end
    end

    // ======================================================================
    // Read port, answer one cycle after the read strobe
    always_comb begin
        rdata_nxt = 8'h00;
        case (i_xfr.addr)
            `PM_OFS_PF_KIND:   rdata_nxt = pf_kind_r;
            `PM_OFS_PA_SEL_HI: rdata_nxt = pa_hi_r;
            `PM_OFS_PA_SEL_LO: rdata_nxt = pa_lo_r;
            `PM_OFS_PB_SEL_HI: rdata_nxt = pb_hi_r;
            `PM_OFS_PB_SEL_LO: rdata_nxt = pb_lo_r;
            `PM_OFS_PC_SEL_HI: rdata_nxt = pc_hi_r;
            `PM_OFS_PC_SEL_LO: rdata_nxt = pc_lo_r;
            `PM_OFS_PG_DIR:    rdata_nxt = {2'h0, port_g_direction_bits};
            `PM_OFS_PG_DATA:   rdata_nxt = {2'h0, pg_in_r};
            `PM_OFS_PG_PULL:   rdata_nxt = {2'h0, port_g_pullup_off_bits};
            default:           rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n)
            o_xfr_rdata <= 8'h00;
        else if (i_xfr.rd)
            o_xfr_rdata <= rdata_nxt;
    end

    // ======================================================================
    // Partner claims
    pm_claim_s claim_nxt;
    always_comb begin
        claim_nxt.sub_xtal       = pa_hi_r[`PM_PA5_BIT];
        claim_nxt.main_xtal      = pa_lo_r[`PM_PA2_BIT];
        claim_nxt.i2c_scl_pe7    = pa_lo_r[`PM_PA3_LSB+:2] == `PM_SEL_ALT1;
        claim_nxt.uart0_tx_b_pc0 = pb_hi_r[7:6] == `PM_SEL_ALT1;
        claim_nxt.uart0_rx_a_pb0 = pb_lo_r[3:2] == `PM_SEL_ALT1;
    end

    // ======================================================================
    // Port A routing
    pm_port_route_s pa_nxt, pb_nxt, pc_nxt;
    always_comb begin
        pa_nxt.pin[7] = route_of(pa_hi_r[`PM_PA7_LSB+:2], 4'h0);
        pa_nxt.pin[6] = route_of(pa_hi_r[`PM_PA6_LSB+:2], 4'h8);
        pa_nxt.pin[5] = claim_nxt.sub_xtal ? PM_RT_ALT1 : PM_RT_GPIO;
        pa_nxt.pin[4] = claim_nxt.sub_xtal ? PM_RT_CLAIM : PM_RT_GPIO;
        pa_nxt.pin[3] = route_of(pa_lo_r[`PM_PA3_LSB+:2], 4'h0);
        pa_nxt.pin[2] = claim_nxt.main_xtal ? PM_RT_ALT1 : PM_RT_GPIO;
        pa_nxt.pin[1] = claim_nxt.main_xtal ? PM_RT_CLAIM : PM_RT_GPIO;
        pa_nxt.pin[0] = pa_lo_r[`PM_PA0_BIT] ? PM_RT_ALT1 : PM_RT_GPIO;
    end

    // ======================================================================
    // Port B and C routing, one field per pin
    logic [15:0] pb_fields, pc_fields;
    assign pb_fields = {pb_hi_r, pb_lo_r};
    assign pc_fields = {pc_hi_r, pc_lo_r};

    for (genvar g = 0; g < 8; g++) begin : g_bc
        localparam logic [3:0] PC_RESV = (g == 0) ? 4'h2 : 4'h8;
        always_comb begin
            if (g == 0 && claim_nxt.uart0_rx_a_pb0)
                pb_nxt.pin[g] = PM_RT_CLAIM;
            else
                pb_nxt.pin[g] = route_of(pb_fields[2*g+:2], 4'h0);
            if (g == 0 && claim_nxt.uart0_tx_b_pc0)
                pc_nxt.pin[g] = PM_RT_CLAIM;
            else
                pc_nxt.pin[g] = route_of(pc_fields[2*g+:2], PC_RESV);
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pa_route <= '0;
            o_pb_route <= '0;
            o_pc_route <= '0;
            o_claim    <= '0;
        end else begin
            o_pa_route <= pa_nxt;
            o_pb_route <= pb_nxt;
            o_pc_route <= pc_nxt;
            o_claim    <= claim_nxt;
        end
    end

    // ======================================================================
    // Checks
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    pg_dir_write_a: assert property (
        i_xfr.wr && i_xfr.addr == `PM_OFS_PG_DIR
        |=> o_pg_oe == $past(i_xfr.wdata[PG_W-1:0]))
        else $error("port G direction not taken from write");

    pg_data_write_a: assert property (
        i_xfr.wr && i_xfr.addr == `PM_OFS_PG_DATA
        |=> o_pg_out == $past(i_xfr.wdata[PG_W-1:0]))
        else $error("port G output data not taken from write");

    pg_data_read_a: assert property (
        i_xfr.rd && i_xfr.addr == `PM_OFS_PG_DATA
        |=> o_xfr_rdata == {2'h0, $past(pg_in_r)})
        else $error("port G read does not return pin values");

    pg_pullup_sense_a: assert property (
        i_xfr.wr && i_xfr.addr == `PM_OFS_PG_PULL
        |=> o_pg_pullup_en == ~$past(i_xfr.wdata[PG_W-1:0]))
        else $error("port G pull-up sense inverted");

    pf_pin3_open_a: assert property (
        i_xfr.wr && i_xfr.addr == `PM_OFS_PF_KIND
        |=> !o_pf_output_kind_bits[`PM_PF_IN_ONLY_BIT])
        else $error("port F pin 3 set to push-pull");

    pf_kind_low_a: assert property (
        i_xfr.wr && i_xfr.addr == `PM_OFS_PF_KIND
        |=> o_pf_output_kind_bits[2:0] == $past(i_xfr.wdata[2:0]))
        else $error("port F output kind bits not stored");

    pa7_route_a: assert property (
        i_xfr.wr && i_xfr.addr == `PM_OFS_PA_SEL_HI && i_xfr.wdata[7:6] == `PM_SEL_ALT3
        |=> ##1 o_pa_route.pin[7] == PM_RT_ALT3)
        else $error("PA7 ADC route missing");

    pa6_none_a: assert property (
        i_xfr.wr && i_xfr.addr == `PM_OFS_PA_SEL_HI && i_xfr.wdata[5:4] == `PM_SEL_ALT3
        |=> ##1 o_pa_route.pin[6] == PM_RT_NONE)
        else $error("PA6 code 11 not routed to nothing");

    sub_xtal_pair_a: assert property (
        (o_pa_route.pin[4] == PM_RT_CLAIM) == (o_pa_route.pin[5] == PM_RT_ALT1))
        else $error("sub crystal pins not paired");

    i2c_claim_a: assert property (
        o_claim.i2c_scl_pe7 == (o_pa_route.pin[3] == PM_RT_ALT1))
        else $error("I2C SDA without SCL claim");

    main_xtal_pair_a: assert property (
        i_xfr.wr && i_xfr.addr == `PM_OFS_PA_SEL_LO && i_xfr.wdata[`PM_PA2_BIT]
        |=> ##1 o_pa_route.pin[2] == PM_RT_ALT1 && o_pa_route.pin[1] == PM_RT_CLAIM)
        else $error("main crystal pins not paired");

    pa0_mosi_a: assert property (
        $rose(pa_lo_r[`PM_PA0_BIT]) |=> o_pa_route.pin[0] == PM_RT_ALT1)
        else $error("PA0 MOSI route missing");

    uart_b_claim_a: assert property (
        o_pb_route.pin[7] == PM_RT_ALT1 |-> o_pc_route.pin[0] == PM_RT_CLAIM)
        else $error("PC0 not claimed by PB7 receive");

    uart_a_claim_a: assert property (
        o_pb_route.pin[1] == PM_RT_ALT1 |-> o_pb_route.pin[0] == PM_RT_CLAIM)
        else $error("PB0 not claimed by PB1 transmit");

    pc_reserved_a: assert property (
        i_xfr.wr && i_xfr.addr == `PM_OFS_PC_SEL_HI && i_xfr.wdata[7:6] == `PM_SEL_ALT3
        |=> ##1 o_pc_route.pin[7] == PM_RT_NONE)
        else $error("PC7 reserved code routed");

    claim_keeps_field_a: assert property (
        i_xfr.wr && i_xfr.addr == `PM_OFS_PB_SEL_LO && i_xfr.wdata[3:2] == `PM_SEL_ALT1
        ##1 !i_xfr.wr
        ##1 (i_xfr.rd && i_xfr.addr == `PM_OFS_PB_SEL_LO && !i_xfr.wr)
        |=> o_xfr_rdata == $past(i_xfr.wdata, 3))
        else $error("claimed field not read back as written");

    pa3_route_a: assert property (
        i_xfr.wr && i_xfr.addr == `PM_OFS_PA_SEL_LO
        |=> ##1 o_pa_route.pin[3] == pm_route_e'({1'b0, $past(i_xfr.wdata[7:6], 2)}))
        else $error("PA3 route does not follow its field");

    pb7_route_a: assert property (
        i_xfr.wr && i_xfr.addr == `PM_OFS_PB_SEL_HI
        |=> ##1 o_pb_route.pin[7] == pm_route_e'({1'b0, $past(i_xfr.wdata[7:6], 2)}))
        else $error("PB7 route does not follow its field");

    pb6_route_a: assert property (
        i_xfr.wr && i_xfr.addr == `PM_OFS_PB_SEL_HI
        |=> ##1 o_pb_route.pin[6] == pm_route_e'({1'b0, $past(i_xfr.wdata[5:4], 2)}))
        else $error("PB6 route does not follow its field");

    pb5_route_a: assert property (
        i_xfr.wr && i_xfr.addr == `PM_OFS_PB_SEL_HI
        |=> ##1 o_pb_route.pin[5] == pm_route_e'({1'b0, $past(i_xfr.wdata[3:2], 2)}))
        else $error("PB5 route does not follow its field");

    pb4_route_a: assert property (
        i_xfr.wr && i_xfr.addr == `PM_OFS_PB_SEL_HI
        |=> ##1 o_pb_route.pin[4] == pm_route_e'({1'b0, $past(i_xfr.wdata[1:0], 2)}))
        else $error("PB4 route does not follow its field");

    pb32_route_a: assert property (
        i_xfr.wr && i_xfr.addr == `PM_OFS_PB_SEL_LO
        |=> ##1 o_pb_route.pin[3] == pm_route_e'({1'b0, $past(i_xfr.wdata[7:6], 2)})
            && o_pb_route.pin[2] == pm_route_e'({1'b0, $past(i_xfr.wdata[5:4], 2)}))
        else $error("PB3 or PB2 route does not follow its field");

    pb0_own_route_a: assert property (
        i_xfr.wr && i_xfr.addr == `PM_OFS_PB_SEL_LO && i_xfr.wdata[3:2] != `PM_SEL_ALT1
        |=> ##1 o_pb_route.pin[0] == pm_route_e'({1'b0, $past(i_xfr.wdata[1:0], 2)}))
        else $error("unclaimed PB0 route does not follow its field");

    pc_low_reserved_a: assert property (
        i_xfr.wr && i_xfr.addr == `PM_OFS_PC_SEL_LO && i_xfr.wdata[7:6] == `PM_SEL_ALT3
        |=> ##1 o_pc_route.pin[3] == PM_RT_NONE)
        else $error("PC3 reserved code routed");

    pc0_reserved_a: assert property (
        i_xfr.wr && i_xfr.addr == `PM_OFS_PC_SEL_LO && i_xfr.wdata[1:0] == `PM_SEL_ALT1
        |=> ##1 o_pc_route.pin[0] == (o_claim.uart0_tx_b_pc0 ? PM_RT_CLAIM : PM_RT_NONE))
        else $error("PC0 reserved code routed");

    pg_filter_a: assert property (
        (($past(pg_in_r) ^ pg_in_r) & $past(pg_s2_r ^ pg_s3_r)) == '0)
        else $error("port G pin value moved without two agreeing samples");

    claim_field_hold_a: assert property (
        o_claim.uart0_rx_a_pb0 && !(i_xfr.wr && i_xfr.addr == `PM_OFS_PB_SEL_LO)
        |=> $stable(pb_lo_r))
        else $error("claimed partner field changed without a write");

    sub_xtal_c:  cover property (o_pa_route.pin[4] == PM_RT_CLAIM);
    main_xtal_c: cover property (o_pa_route.pin[1] == PM_RT_CLAIM);
    uart_b_c:    cover property (o_pc_route.pin[0] == PM_RT_CLAIM);
    uart_a_c:    cover property (o_pb_route.pin[0] == PM_RT_CLAIM);
    pg_io_c:     cover property (o_pg_oe != '0 && o_pg_pullup_en != '0);

endmodule : pm_port_mux

// ===== pm_pin_model.sv
// Package pin model for port G, the far side of the port function mux.
// Assumes one system clock; the board may drive pins through i_ext_en.
`timescale 1ns/1ps

module pm_pin_model #(
    parameter int PG_W = 6
) (
    // Clock
    input  wire logic            i_sys_clk,
    // Block side
    input  wire logic [PG_W-1:0] i_out,
    input  wire logic [PG_W-1:0] i_oe,
    input  wire logic [PG_W-1:0] i_pullup_en,
    // Board side
    input  wire logic [PG_W-1:0] i_ext_en,
    input  wire logic [PG_W-1:0] i_ext_val,
    output logic      [PG_W-1:0] o_pin
);
    // ======================================================================
    // Undriven pin without pull-up wanders every cycle
    logic [PG_W-1:0] float_r;

    initial float_r = '0;

    always @(posedge i_sys_clk) begin
        float_r <= ~float_r;
    end

    // ======================================================================
    // Pin level resolution
    always_comb begin
        for (int i = 0; i < PG_W; i++) begin
            if (i_oe[i]) begin
                o_pin[i] = i_out[i];
            end else if (i_ext_en[i]) begin
                o_pin[i] = i_ext_val[i];
            end else if (i_pullup_en[i]) begin
                o_pin[i] = 1'b1;
            end else begin
                o_pin[i] = float_r[i];
            end
        end
    end
endmodule : pm_pin_model

// ===== test_pm_port_mux.sv
// Self-checking bench for the port function mux.
// Assumes pm_defs.svh, pm_pkg.sv, pm_port_mux.sv and pm_pin_model.sv.
`timescale 1ns/1ps
`include "pm_defs.svh"

module test_pm_port_mux;
    import pm_pkg::*;

    // ======================================================================
    // Signals
    logic           i_sys_clk;
    logic           i_rst_n;
    pm_xfr_req_s    xfr;
    logic [7:0]     rdata;
    logic [5:0]     pg_pin, pg_out, pg_oe, pg_pu, ext_en, ext_val;
    logic [7:0]     pf_kind;
    pm_port_route_s pa_rt, pb_rt, pc_rt, ea, eb, ec;
    pm_claim_s      claim;
    logic [1:0]     c;
    logic [1:0]     codes [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    logic [11:0]    ofs [9] = '{`PM_OFS_PA_SEL_HI, `PM_OFS_PA_SEL_LO, `PM_OFS_PB_SEL_HI,
                                `PM_OFS_PB_SEL_LO, `PM_OFS_PC_SEL_HI, `PM_OFS_PC_SEL_LO,
                                `PM_OFS_PG_DIR, `PM_OFS_PG_PULL, `PM_OFS_PF_KIND};
    logic [7:0]     rst [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3F, 8'hF7};
    logic [7:0]     msk [9] = '{8'hF8, 8'hE2, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'h3F, 8'hF7};
    int             fail_count;
    int             comparisons;

    pm_port_mux #(.PG_W(6)) dut (
        .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_xfr(xfr), .o_xfr_rdata(rdata),
        .i_pg_pin(pg_pin), .o_pg_out(pg_out), .o_pg_oe(pg_oe), .o_pg_pullup_en(pg_pu),
        .o_pf_output_kind_bits(pf_kind), .o_pa_route(pa_rt), .o_pb_route(pb_rt),
        .o_pc_route(pc_rt), .o_claim(claim)
    );

    pm_pin_model #(.PG_W(6)) pins (
        .i_sys_clk(i_sys_clk), .i_out(pg_out), .i_oe(pg_oe), .i_pullup_en(pg_pu),
        .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pin(pg_pin)
    );

    initial i_sys_clk = 1'b0;
    always #10 i_sys_clk = ~i_sys_clk;

    // ======================================================================
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%0h expected=%0h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        xfr.wr    <= 1'b1;
        xfr.addr  <= a;
        xfr.wdata <= d;
        @(posedge i_sys_clk);
        xfr.wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge i_sys_clk);
        xfr.rd   <= 1'b1;
        xfr.addr <= a;
        @(posedge i_sys_clk);
        xfr.rd   <= 1'b0;
        #1;
        check(rdata, exp);
    endtask : rd

    task automatic settle(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask : settle

    task automatic final_report;
        $display("comparisons=%0d mismatches=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report

    // ======================================================================
    // Hang guard
    initial begin
        #1000000;
        fail_count++;
        final_report();
    end

    // ======================================================================
    // Main sequence
    initial begin
        fail_count = 0;
        comparisons = 0;
        i_rst_n = 1'b0;
        xfr = '0;
        ext_en = '0;
        ext_val = '0;
        repeat (6) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        settle(1);
        check(pg_oe, 6'h00);
        check(pg_pu, 6'h00);
        check(pf_kind, 8'hF7);
        for (int i = 0; i < 9; i++) begin
            rd(ofs[i], rst[i]);
        end
        for (int i = 0; i < 9; i++) begin
            wr(ofs[i], 8'hFF);
            rd(ofs[i], msk[i]);
            wr(ofs[i], rst[i]);
        end
        wr(12'h02B, 8'hFF);
        rd(12'h02B, 8'h00);
        $display("test registers done");

        wr(`PM_OFS_PG_DIR, 8'h3F);
        wr(`PM_OFS_PG_DATA, 8'h2A);
        settle(1);
        check(pg_oe, 6'h3F);
        check(pg_out, 6'h2A);
        settle(4);
        rd(`PM_OFS_PG_DATA, 8'h2A);
        wr(`PM_OFS_PG_DIR, 8'h00);
        wr(`PM_OFS_PG_PULL, 8'h0A);
        settle(1);
        check(pg_pu, 6'h35);
        wr(`PM_OFS_PG_PULL, 8'h00);
        settle(5);
        rd(`PM_OFS_PG_DATA, 8'h3F);
        ext_en <= 6'h3F;
        ext_val <= 6'h15;
        wr(`PM_OFS_PG_DATA, 8'h00);
        settle(5);
        rd(`PM_OFS_PG_DATA, 8'h15);
        wr(`PM_OFS_PG_PULL, 8'h3F);
        wr(`PM_OFS_PF_KIND, 8'h0D);
        settle(1);
        check(pf_kind, 8'h05);
        $display("test port g and f done");

        foreach (codes[k]) begin
            c = codes[k];
            wr(`PM_OFS_PA_SEL_HI, {c, c, c[0], 3'b000});
            wr(`PM_OFS_PA_SEL_LO, {c, c[0], 3'b000, c[0], 1'b0});
            wr(`PM_OFS_PB_SEL_HI, {4{c}});
            wr(`PM_OFS_PB_SEL_LO, {4{c}});
            wr(`PM_OFS_PC_SEL_HI, {4{c}});
            wr(`PM_OFS_PC_SEL_LO, {4{c}});
            settle(2);
            for (int p = 0; p < 8; p++) begin
                eb.pin[p] = pm_route_e'({1'b0, c});
                ec.pin[p] = (c == 2'h3) ? PM_RT_NONE : pm_route_e'({1'b0, c});
            end
            ea = eb;
            ea.pin[6] = ec.pin[6];
            ea.pin[5] = c[0] ? PM_RT_ALT1 : PM_RT_GPIO;
            ea.pin[4] = c[0] ? PM_RT_CLAIM : PM_RT_GPIO;
            ea.pin[2] = ea.pin[5];
            ea.pin[1] = ea.pin[4];
            ea.pin[0] = ea.pin[5];
            ec.pin[0] = (c == 2'h3) ? PM_RT_ALT3 : ec.pin[0];
            if (c == 2'h1) begin
                eb.pin[0] = PM_RT_CLAIM;
                ec.pin[0] = PM_RT_CLAIM;
            end
            check(pa_rt, ea);
            check(pb_rt, eb);
            check(pc_rt, ec);
            check(claim, {c[0], c[0], c == 2'h1, c == 2'h1, c == 2'h1});
            rd(`PM_OFS_PB_SEL_LO, {4{c}});
            rd(`PM_OFS_PC_SEL_LO, {4{c}});
        end
        $display("test routing done");

        wr(`PM_OFS_PA_SEL_HI, 8'h08);
        wr(`PM_OFS_PA_SEL_LO, 8'h20);
        wr(`PM_OFS_PC_SEL_LO, 8'h01);
        wr(`PM_OFS_PB_SEL_LO, 8'h55);
        rd(`PM_OFS_PB_SEL_LO, 8'h55);
        settle(1);
        check(pa_rt.pin[4], PM_RT_CLAIM);
        check(pa_rt.pin[1], PM_RT_CLAIM);
        check(pc_rt.pin[0], PM_RT_NONE);
        check(pb_rt.pin[0], PM_RT_CLAIM);
        $display("test claims done");
        final_report();
    end
endmodule : test_pm_port_mux
